// ===== design/lelr_pkg.sv
package lelr_pkg;
    // function codes and exception answers
    localparam logic [7:0] FC_RD = 8'h03;
    localparam logic [7:0] FC_WR = 8'h10;
    localparam logic [7:0] FC_RW = 8'h17;
    localparam logic [7:0] EXC_FLAG = 8'h80;
    localparam logic [7:0] EXC_NONE = 8'h00;
    localparam logic [7:0] EXC_FUNC = 8'h01;
    localparam logic [7:0] EXC_DATA = 8'h03;
    // register addresses as carried on the wire
    localparam logic [15:0] PT_REPLY = 16'h7531;
    localparam logic [15:0] RELAY = 16'h80E9;
    localparam logic [15:0] CNT_A = 16'h84D1;
    localparam logic [15:0] REC_A = 16'h84D2;
    localparam logic [15:0] CNT_B = 16'h88B9;
    localparam logic [15:0] REC_B = 16'h88BA;
    localparam logic [15:0] PT_CMD = 16'h9C41;
    localparam logic [15:0] GEAR = 16'hA029;
    // window sizes in registers
    localparam logic [15:0] PT_REPLY_N = 16'h0004;
    localparam logic [15:0] RELAY_N = 16'h0004;
    localparam logic [15:0] CNT_N = 16'h0001;
    localparam logic [15:0] REC_N = 16'h0100;
    localparam logic [15:0] PT_CMD_N = 16'h0006;
    localparam logic [15:0] GEAR_N = 16'h0004;
    localparam int LOG_DEPTH = 128;
    // pdu byte positions
    localparam logic [8:0] HDR_RD = 9'h005;
    localparam logic [8:0] HDR_WR = 9'h006;
    localparam logic [8:0] HDR_RW = 9'h00A;
    localparam logic [8:0] WR_ACK_LEN = 9'h005;
    localparam logic [8:0] EXC_LEN = 9'h002;
    // event field limits
    localparam logic [7:0] ADDR_MAX = 8'h3F;
    localparam logic [7:0] INST_MIN = 8'h01;
    localparam logic [7:0] INST_MAX = 8'h20;
    localparam logic [7:0] TYPE_BUTTON = 8'h01;
    localparam logic [7:0] TYPE_SLIDER = 8'h02;
    localparam logic [7:0] TYPE_OCC = 8'h03;
    localparam logic [7:0] TYPE_LIGHT = 8'h04;
    localparam logic [7:0] BTN_MAX = 8'h09;
    localparam logic [7:0] OCC_MAX = 8'h03;
    localparam logic [7:0] CODE_MIN = 8'h01;
    localparam logic [7:0] PCT_MAX = 8'h64;

    // one input-device event, byte 0 first
    typedef struct packed {
        logic [7:0] dev_addr;
        logic [7:0] inst;
        logic [7:0] itype;
        logic [7:0] info;
    } lelr_evt_t;

    // one register write towards the command windows
    typedef struct packed {
        logic valid;
        logic [15:0] addr;
        logic [15:0] data;
    } lelr_wr_t;
endpackage

// ===== design/lelr_event_log.sv
`timescale 1ns/1ps
// circular store of event records for one lighting bus
module lelr_event_log #(
    parameter int DEPTH = lelr_pkg::LOG_DEPTH,
    parameter bit CLEAR_ON_WRAP = 1'b0
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_evt_valid,
    input wire lelr_pkg::lelr_evt_t i_evt,
    input wire logic [7:0] i_rd_idx,
    output logic [15:0] o_rd_word,
    output logic [7:0] o_count
);
    typedef struct packed {
        logic [6:0] wptr;  // next slot to fill
        logic [7:0] count; // events on record
        logic pend;        // record written, count not yet
    } lelr_log_st_t;

    lelr_log_st_t st_reg, st_next;
    lelr_pkg::lelr_evt_t mem [DEPTH]; // record store
    lelr_pkg::lelr_evt_t rec;
    logic ok;

    ////////////////////////////////////////////////////////////////////
    // accept only events whose fields are all legal
    always_comb begin
        ok = i_evt_valid && i_evt.dev_addr <= lelr_pkg::ADDR_MAX // R03
            && i_evt.inst >= lelr_pkg::INST_MIN
            && i_evt.inst <= lelr_pkg::INST_MAX; // R03
        case (i_evt.itype) // R04
            lelr_pkg::TYPE_BUTTON: begin
                ok = ok && i_evt.info >= lelr_pkg::CODE_MIN
                    && i_evt.info <= lelr_pkg::BTN_MAX; // R05
            end
            lelr_pkg::TYPE_SLIDER, lelr_pkg::TYPE_LIGHT: begin
                ok = ok && i_evt.info <= lelr_pkg::PCT_MAX; // R06
            end
            lelr_pkg::TYPE_OCC: begin
                ok = ok && i_evt.info >= lelr_pkg::CODE_MIN
                    && i_evt.info <= lelr_pkg::OCC_MAX; // R07
            end
            default: begin
                ok = 1'b0; // reserved types are never stored
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // pointer wrap and count update, count one cycle after the record
    always_comb begin
        st_next = st_reg;
        st_next.pend = ok;
        if (ok) begin
            st_next.wptr = (32'(st_reg.wptr) == DEPTH - 1) ? 7'h00
                : st_reg.wptr + 7'h01; // R10 R12
        end
        if (st_reg.pend) begin // R19
            if (32'(st_reg.count) == DEPTH) begin
                st_next.count = CLEAR_ON_WRAP ? 8'h01 : st_reg.count; // R11
            end else begin
                st_next.count = st_reg.count + 8'h01; // R02
            end
        end
    end

    // state register
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // record store, two registers per slot
    always_ff @(posedge i_core_clk) begin
        if (ok) begin
            mem[st_reg.wptr] <= i_evt; // R08
        end
    end

    // read port: even index is bytes 0 and 1, odd is bytes 2 and 3
    always_comb begin
        rec = mem[i_rd_idx[7:1]];
        o_rd_word = i_rd_idx[0] ? {rec.itype, rec.info}
            : {rec.dev_addr, rec.inst}; // R09
    end
    assign o_count = st_reg.count;

    ////////////////////////////////////////////////////////////////////
    // checks
    count_max_a: assert property (@(posedge i_core_clk) // R02
        disable iff (!i_rst_n) 32'(o_count) <= DEPTH)
        else $error("event count above depth");
    count_late_a: assert property (@(posedge i_core_clk) // R19
        disable iff (!i_rst_n) ok && !st_reg.pend
        && (CLEAR_ON_WRAP || 32'(o_count) != DEPTH)
        |=> $stable(o_count) ##1 !$stable(o_count))
        else $error("count not updated one cycle after record");
    ptr_wrap_a: assert property (@(posedge i_core_clk) // R10
        disable iff (!i_rst_n) ok && 32'(st_reg.wptr) == DEPTH - 1
        |=> st_reg.wptr == 7'h00)
        else $error("write slot did not wrap to first record");
    cnt_clear_a: assert property (@(posedge i_core_clk) // R11
        disable iff (!i_rst_n) CLEAR_ON_WRAP && st_reg.pend
        && 32'(o_count) == DEPTH |=> o_count == 8'h01)
        else $error("count did not restart after overflow");
    log_wrap_c: cover property (@(posedge i_core_clk)
        disable iff (!i_rst_n) ok && 32'(st_reg.wptr) == DEPTH - 1);
endmodule

// ===== design/lelr_regs.sv
`timescale 1ns/1ps
// What this block does
// R01: relay state byte: 0 open, 1 closed
// R02: bus A count register holds 0 to 128
// R03: record bytes 0,1: address 0-63, instance 1-32
// R04: record byte 2: type 1-4 only
// R05: button event codes 1 to 9
// R06: slider and light sensor: percent 0-100
// R07: occupancy codes 1 to 3
// R08: each record spans two registers, 128 records
// R09: bus A records at 34002 to 34257
// R10: bus A overwrites oldest after 128 events
// R11: bus B count restarts after 128
// R12: bus B records at 35002 to 35257, wrapping
// R13: combined read/write request field order
// R14: client passes commands via 40001 and 30001
// R15: combined reply: code, byte count, data
// R16: client writes gear control at 41001
// R17: write reply echoes start and count
// R18: errors: code with top bit, exception byte
// R19: record written before its count moves
module lelr_regs (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_data,
    input wire logic i_rx_last,
    output logic o_rx_ready,
    output logic o_tx_valid,
    output logic [7:0] o_tx_data,
    output logic o_tx_last,
    input wire logic i_tx_ready,
    input wire logic [3:0] i_relay_closed,
    input wire logic [63:0] i_pt_reply,
    input wire logic [1:0] i_evt_valid,
    input wire lelr_pkg::lelr_evt_t [1:0] i_evt,
    output lelr_pkg::lelr_wr_t o_wr
);
    ////////////////////////////////////////////////////////////////////
    // state
    typedef enum logic [2:0] {
        ST_RX = 3'b001,   // collecting a request
        ST_EVAL = 3'b010, // judging the full request
        ST_TX = 3'b100    // sending the reply
    } lelr_state_t;

    typedef struct packed {
        lelr_state_t st;
        logic [7:0] fc;    // function code
        logic [15:0] f0;   // first address field
        logic [15:0] f1;   // first count field
        logic [15:0] f2;   // second address field
        logic [15:0] f3;   // second count field
        logic [7:0] bc;    // byte count field
        logic [8:0] cnt;   // bytes taken so far
        logic [7:0] hi;    // high byte of a write word
        logic [7:0] exc;   // exception code, zero if none
        logic [8:0] tx_idx;
        logic [8:0] tx_len;
        logic [7:0] tx_data;
        lelr_pkg::lelr_wr_t wr;
    } lelr_st_t;

    lelr_st_t st_reg, st_next;
    logic [15:0] rd_start, rd_qty, wr_start, wr_qty;
    logic [8:0] hdr_len;    // bytes ahead of the write data
    logic fc_ok;            // supported function
    logic rd_ok, wr_ok;     // windows legal
    logic len_ok;           // lengths agree
    logic [8:0] p, pm2;     // next reply byte position
    logic [15:0] rd_addr, rd_word, rd_off;
    logic [7:0] byte_p;
    logic [8:0] didx;       // index within write data
    logic [7:0] log_idx [2];
    logic [15:0] log_word [2];
    logic [7:0] log_cnt [2];

    // true when start..start+qty-1 lies inside base..base+n-1
    function automatic logic in_win(input logic [15:0] s,
        input logic [15:0] q, input logic [15:0] b, input logic [15:0] n);
        logic [16:0] e;
        e = {1'b0, s} + {1'b0, q};
        in_win = q != 16'h0000 && s >= b && e <= {1'b0, b} + {1'b0, n};
    endfunction

    ////////////////////////////////////////////////////////////////////
    // one event log per bus, the second restarts its count
    for (genvar g = 0; g < 2; g++) begin : g_log
        lelr_event_log #(
            .DEPTH(lelr_pkg::LOG_DEPTH),
            .CLEAR_ON_WRAP(g == 1)
        ) u_log (
            .i_core_clk(i_core_clk),
            .i_rst_n(i_rst_n),
            .i_evt_valid(i_evt_valid[g]),
            .i_evt(i_evt[g]),
            .i_rd_idx(log_idx[g]),
            .o_rd_word(log_word[g]),
            .o_count(log_cnt[g])
        );
    end

    ////////////////////////////////////////////////////////////////////
    // request fields by function code
    always_comb begin
        rd_start = st_reg.f0;
        rd_qty = st_reg.f1;
        wr_start = (st_reg.fc == lelr_pkg::FC_WR) ? st_reg.f0 : st_reg.f2;
        wr_qty = (st_reg.fc == lelr_pkg::FC_WR) ? st_reg.f1 : st_reg.f3;
        case (st_reg.fc) // R13
            lelr_pkg::FC_RD: begin
                hdr_len = lelr_pkg::HDR_RD;
            end
            lelr_pkg::FC_WR: begin
                hdr_len = lelr_pkg::HDR_WR;
            end
            default: begin
                hdr_len = lelr_pkg::HDR_RW;
            end
        endcase
        fc_ok = st_reg.fc == lelr_pkg::FC_RD
            || st_reg.fc == lelr_pkg::FC_WR
            || st_reg.fc == lelr_pkg::FC_RW;
        rd_ok = in_win(rd_start, rd_qty, lelr_pkg::PT_REPLY,
                lelr_pkg::PT_REPLY_N)
            || in_win(rd_start, rd_qty, lelr_pkg::RELAY, lelr_pkg::RELAY_N)
            || in_win(rd_start, rd_qty, lelr_pkg::CNT_A, lelr_pkg::CNT_N
                + lelr_pkg::REC_N)
            || in_win(rd_start, rd_qty, lelr_pkg::CNT_B, lelr_pkg::CNT_N
                + lelr_pkg::REC_N);
        wr_ok = (in_win(wr_start, wr_qty, lelr_pkg::PT_CMD,
                lelr_pkg::PT_CMD_N)
            || in_win(wr_start, wr_qty, lelr_pkg::GEAR, lelr_pkg::GEAR_N))
            && {8'h00, st_reg.bc} == {wr_qty[14:0], 1'b0};
        len_ok = st_reg.cnt == hdr_len + {1'b0, st_reg.bc};
    end

    ////////////////////////////////////////////////////////////////////
    // register read mux for the next reply byte
    always_comb begin
        p = st_reg.tx_idx + 9'h001;
        pm2 = p - 9'h002;
        rd_addr = rd_start + {8'h00, pm2[8:1]};
        log_idx[0] = 8'(rd_addr - lelr_pkg::REC_A);
        log_idx[1] = 8'(rd_addr - lelr_pkg::REC_B);
        rd_word = 16'h0000;
        if (in_win(rd_addr, 16'h0001, lelr_pkg::PT_REPLY,
                lelr_pkg::PT_REPLY_N)) begin
            rd_off = rd_addr - lelr_pkg::PT_REPLY;
            rd_word = i_pt_reply[16 * (3 - rd_off[1:0]) +: 16];
        end else if (in_win(rd_addr, 16'h0001, lelr_pkg::RELAY,
                lelr_pkg::RELAY_N)) begin
            rd_off = rd_addr - lelr_pkg::RELAY;
            rd_word = {7'h00, i_relay_closed[rd_off[1:0]], 8'h00}; // R01
        end else if (rd_addr == lelr_pkg::CNT_A) begin
            rd_off = 16'h0000;
            rd_word = {log_cnt[0], 8'h00}; // R02
        end else if (rd_addr == lelr_pkg::CNT_B) begin
            rd_off = 16'h0000;
            rd_word = {log_cnt[1], 8'h00}; // R11
        end else if (rd_addr < lelr_pkg::CNT_B) begin
            rd_off = 16'h0000;
            rd_word = log_word[0]; // R09
        end else begin
            rd_off = 16'h0000;
            rd_word = log_word[1]; // R12
        end
        // reply byte at position p
        if (st_reg.exc != lelr_pkg::EXC_NONE) begin
            byte_p = st_reg.exc; // R18
        end else if (st_reg.fc == lelr_pkg::FC_WR) begin
            case (p[2:0]) // R17
                3'h1: begin
                    byte_p = wr_start[15:8];
                end
                3'h2: begin
                    byte_p = wr_start[7:0];
                end
                3'h3: begin
                    byte_p = wr_qty[15:8];
                end
                default: begin
                    byte_p = wr_qty[7:0];
                end
            endcase
        end else if (p == 9'h001) begin
            byte_p = {rd_qty[6:0], 1'b0}; // R15
        end else begin
            byte_p = pm2[0] ? rd_word[7:0] : rd_word[15:8]; // R15
        end
    end

    ////////////////////////////////////////////////////////////////////
    // request intake, judging and reply sequencing
    always_comb begin
        st_next = st_reg;
        st_next.wr.valid = 1'b0;
        didx = st_reg.cnt - hdr_len;
        case (st_reg.st)
            ST_RX: begin
                if (i_rx_valid) begin
                    st_next.cnt = st_reg.cnt + 9'h001;
                    case (st_reg.cnt)
                        9'h000: begin
                            st_next.fc = i_rx_data;
                        end
                        9'h001, 9'h002: begin
                            st_next.f0 = {st_reg.f0[7:0], i_rx_data};
                        end
                        9'h003, 9'h004: begin
                            st_next.f1 = {st_reg.f1[7:0], i_rx_data};
                        end
                        9'h005, 9'h006, 9'h007, 9'h008: begin
                            if (st_reg.fc == lelr_pkg::FC_RW) begin // R13
                                if (st_reg.cnt[8:1] == 8'h02 ||
                                        st_reg.cnt == 9'h006) begin
                                    st_next.f2 = {st_reg.f2[7:0],
                                        i_rx_data};
                                end else begin
                                    st_next.f3 = {st_reg.f3[7:0],
                                        i_rx_data};
                                end
                            end
                        end
                        default: begin
                        end
                    endcase
                    // byte count sits just ahead of the write data
                    if (st_reg.cnt == hdr_len - 9'h001 &&
                            st_reg.fc != lelr_pkg::FC_RD) begin
                        st_next.bc = i_rx_data;
                    end
                    // pair data bytes into words for the windows
                    if (st_reg.cnt >= hdr_len && fc_ok && wr_ok &&
                            st_reg.fc != lelr_pkg::FC_RD) begin
                        if (!didx[0]) begin
                            st_next.hi = i_rx_data;
                        end else if ({8'h00, didx[8:1]} < wr_qty) begin
                            st_next.wr.valid = 1'b1;
                            st_next.wr.addr = wr_start
                                + {8'h00, didx[8:1]};
                            st_next.wr.data = {st_reg.hi, i_rx_data};
                        end
                    end
                    if (i_rx_last) begin
                        st_next.st = ST_EVAL;
                    end
                end
            end
            ST_EVAL: begin
                st_next.tx_idx = 9'h000;
                if (!fc_ok) begin
                    st_next.exc = lelr_pkg::EXC_FUNC; // R18
                end else if (!len_ok
                        || (st_reg.fc != lelr_pkg::FC_WR && !rd_ok)
                        || (st_reg.fc != lelr_pkg::FC_RD && !wr_ok)) begin
                    st_next.exc = lelr_pkg::EXC_DATA; // R18
                end
                if (st_next.exc != lelr_pkg::EXC_NONE) begin
                    st_next.tx_len = lelr_pkg::EXC_LEN;
                    st_next.tx_data = st_reg.fc | lelr_pkg::EXC_FLAG;
                end else begin
                    st_next.tx_len = (st_reg.fc == lelr_pkg::FC_WR)
                        ? lelr_pkg::WR_ACK_LEN
                        : {rd_qty[7:0], 1'b0} + 9'h002; // R15
                    st_next.tx_data = st_reg.fc; // R15 R17
                end
                st_next.st = ST_TX;
            end
            ST_TX: begin
                if (i_tx_ready) begin
                    if (p == st_reg.tx_len) begin
                        st_next = '0;
                        st_next.st = ST_RX;
                    end else begin
                        st_next.tx_idx = p;
                        st_next.tx_data = byte_p;
                    end
                end
            end
            default: begin
                st_next = '0;
                st_next.st = ST_RX;
            end
        endcase
    end

    // state register
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg <= '{st: ST_RX, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs
    assign o_rx_ready = st_reg.st == ST_RX;
    assign o_tx_valid = st_reg.st == ST_TX;
    assign o_tx_data = st_reg.tx_data;
    assign o_tx_last = o_tx_valid && p == st_reg.tx_len;
    assign o_wr = st_reg.wr;

    ////////////////////////////////////////////////////////////////////
    // checks
    unsup_code_a: assert property (@(posedge i_core_clk) // R18
        disable iff (!i_rst_n) st_reg.st == ST_EVAL && !fc_ok
        |=> o_tx_valid && o_tx_data == ($past(st_reg.fc) | 8'h80))
        else $error("unsupported code not flagged");
    bad_count_a: assert property (@(posedge i_core_clk) // R13
        disable iff (!i_rst_n) o_tx_valid && st_reg.tx_idx == 9'h001
        && (st_reg.fc == lelr_pkg::FC_RW || st_reg.fc == lelr_pkg::FC_WR)
        && {8'h00, st_reg.bc} != {wr_qty[14:0], 1'b0}
        |-> o_tx_data == 8'h03)
        else $error("bad byte count not answered as illegal data");
    rw_count_a: assert property (@(posedge i_core_clk) // R15
        disable iff (!i_rst_n) o_tx_valid && st_reg.tx_idx == 9'h001
        && st_reg.exc == 8'h00 && st_reg.fc == lelr_pkg::FC_RW
        |-> o_tx_data == 8'(st_reg.f1 * 2))
        else $error("read reply byte count wrong");
    rw_len_a: assert property (@(posedge i_core_clk) // R15
        disable iff (!i_rst_n) o_tx_last && st_reg.exc == 8'h00
        && st_reg.fc == lelr_pkg::FC_RW
        |-> st_reg.tx_idx == 9'(st_reg.f1 * 2 + 1))
        else $error("read reply length wrong");
    wr_echo_a: assert property (@(posedge i_core_clk) // R17
        disable iff (!i_rst_n) o_tx_valid && i_tx_ready
        && st_reg.tx_idx == 9'h000 && st_reg.exc == 8'h00
        && st_reg.fc == lelr_pkg::FC_WR
        |=> o_tx_data == st_reg.f0[15:8] ##1 1'b1)
        else $error("write reply does not echo start");
    relay_word_a: assert property (@(posedge i_core_clk) // R01
        disable iff (!i_rst_n) rd_addr == lelr_pkg::RELAY
        |-> rd_word == {7'h00, i_relay_closed[0], 8'h00})
        else $error("relay word layout wrong");
    wr_window_a: assert property (@(posedge i_core_clk) // R13
        disable iff (!i_rst_n) o_wr.valid |->
        (o_wr.addr >= lelr_pkg::PT_CMD && o_wr.addr < 16'h9C47)
        || (o_wr.addr >= lelr_pkg::GEAR && o_wr.addr < 16'hA02D))
        else $error("write outside command windows");
    rw_done_c: cover property (@(posedge i_core_clk)
        disable iff (!i_rst_n) o_tx_last && i_tx_ready
        && st_reg.fc == lelr_pkg::FC_RW && st_reg.exc == 8'h00);
    wr_done_c: cover property (@(posedge i_core_clk)
        disable iff (!i_rst_n) o_tx_last && i_tx_ready
        && st_reg.fc == lelr_pkg::FC_WR && st_reg.exc == 8'h00);
    exc_c: cover property (@(posedge i_core_clk)
        disable iff (!i_rst_n) o_tx_last && st_reg.exc != 8'h00);
endmodule

// ===== tb/lelr_client.sv
`timescale 1ns/1ps
// network client model: offers request bytes, takes reply bytes
module lelr_client (
    input wire logic i_core_clk,
    input wire logic i_req_ready,
    output logic o_req_valid,
    output logic [7:0] o_req_data,
    output logic o_req_last,
    output logic o_rsp_ready
);
    // idle bus until the first request
    initial begin
        o_req_valid = 1'b0;
        o_req_data = 8'hA5;
        o_req_last = 1'b0;
        o_rsp_ready = 1'b0;
    end
    // reply sink takes bytes promptly or stalls at random
    always @(posedge i_core_clk) begin
        #1;
        o_rsp_ready = ($urandom % 3) != 0;
    end
    // fields go out big-endian, each byte held until taken
    task automatic send(input logic [7:0] q[$]);
        int n;
        foreach (q[k]) begin
            o_req_valid = 1'b1;
            o_req_data = q[k];
            o_req_last = (k == q.size() - 1);
            n = 0;
            while (i_req_ready !== 1'b1 && n < 400) begin
                @(posedge i_core_clk);
                #1;
                n++;
            end
            @(posedge i_core_clk);
            #1;
        end
        // released bus shows no stale byte
        o_req_valid = 1'b0;
        o_req_last = 1'b0;
        o_req_data = ~o_req_data;
    endtask
endmodule

// ===== tb/tb_lelr_regs.sv
`timescale 1ns/1ps
// self-checking bench for the register bank
module tb_lelr_regs;
    logic i_core_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready;
    logic [7:0] rx_data, tx_data;
    logic [3:0] relay = 4'h0;
    logic [63:0] pt = 64'h0;
    logic [1:0] ev_v = 2'b00;
    lelr_pkg::lelr_evt_t [1:0] ev = '0;
    lelr_pkg::lelr_wr_t wr;
    int failures = 0;
    int checks_done = 0;
    logic [8:0] expq[$];
    logic [31:0] wrq[$];
    logic [7:0] b[$];
    logic [7:0] e[$];
    always #5 i_core_clk = ~i_core_clk;
    lelr_regs dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
        .i_rx_valid(rx_valid), .i_rx_data(rx_data), .i_rx_last(rx_last),
        .o_rx_ready(rx_ready), .o_tx_valid(tx_valid), .o_tx_data(tx_data),
        .o_tx_last(tx_last), .i_tx_ready(tx_ready), .i_relay_closed(relay),
        .i_pt_reply(pt), .i_evt_valid(ev_v), .i_evt(ev), .o_wr(wr));
    lelr_client cli (.i_core_clk(i_core_clk), .i_req_ready(rx_ready),
        .o_req_valid(rx_valid), .o_req_data(rx_data), .o_req_last(rx_last),
        .o_rsp_ready(tx_ready));
    ////////////////////////////////////////////////////////////////////
    // verdict and counts
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // one comparison of a reply byte or a write strobe
    task automatic cmp(string n, logic [31:0] x, logic [31:0] g);
        checks_done++;
        if (g !== x) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, x, g);
        end
    endtask
    // watcher: oldest note against each byte taken or strobe seen
    always @(negedge i_core_clk) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            if (expq.size() == 0)
                expq.push_back('x);
            cmp("reply", 32'(expq.pop_front()), {23'h0, tx_last, tx_data});
        end
        if (wr.valid === 1'b1) begin
            if (wrq.size() == 0)
                wrq.push_back('x);
            cmp("strobe", wrq.pop_front(), {wr.addr, wr.data});
        end
    end
    ////////////////////////////////////////////////////////////////////
    // one request, wait for its notes to drain
    task automatic run(string t);
        int n;
        foreach (e[k])
            expq.push_back({k == e.size() - 1, e[k]});
        cli.send(b);
        for (n = 0; (expq.size() != 0 || wrq.size() != 0) && n < 400; n++)
            @(posedge i_core_clk);
        if (n == 400) begin
            failures++;
            close_out();
        end
        repeat (2) @(posedge i_core_clk);
        #1;
        $display("done: %s", t);
    endtask
    // random legal event of the given type
    function automatic lelr_pkg::lelr_evt_t mk(logic [7:0] t);
        logic [7:0] i;
        i = (t == 8'h01) ? 8'(1 + $urandom % 9) : 8'($urandom % 101);
        if (t == 8'h03)
            i = 8'(1 + $urandom % 3);
        return {8'($urandom % 64), 8'(1 + $urandom % 32), t, i};
    endfunction
    // one-cycle event pulse on the buses in m
    task automatic post(logic [1:0] m, lelr_pkg::lelr_evt_t a,
            lelr_pkg::lelr_evt_t c);
        ev = {c, a};
        ev_v = m;
        @(posedge i_core_clk);
        #1;
        ev_v = 2'b00;
        // idle cycle so the next pulse is a fresh assignment
        @(posedge i_core_clk);
        #1;
    endtask
    // record bytes in stored order
    function automatic void pr(lelr_pkg::lelr_evt_t v);
        for (int k = 3; k >= 0; k--)
            e.push_back(v[8*k +: 8]);
    endfunction
    // write data bytes and their strobes
    function automatic void wd(logic [15:0] a, int n);
        logic [15:0] w;
        for (int k = 0; k < n; k++) begin
            w = 16'($urandom);
            b.push_back(w[15:8]);
            b.push_back(w[7:0]);
            wrq.push_back({a + 16'(k), w});
        end
    endfunction
    ////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        lelr_pkg::lelr_evt_t ra, rb;
        void'($urandom(32'h93A6));
        repeat (10) @(posedge i_core_clk);
        #1;
        i_rst_n = 1'b1;
        relay = 4'($urandom);
        b = {8'h03, 8'h80, 8'hE9, 8'h00, 8'h04};
        e = {8'h03, 8'h08};
        for (int r = 0; r < 4; r++)
            e.push_back({7'h00, relay[r]});
        for (int r = 0; r < 4; r++)
            e.insert(3 + 2 * r, 8'h00);
        run("relay read");
        for (int k = 0; k < 129; k++) begin
            ra = mk(8'(1 + k % 4));
            rb = mk(8'(1 + (k + 1) % 4));
            post(2'b11, ra, rb);
        end
        post(2'b01, {8'h00, 8'h01, 8'h05, 8'h01}, ra);
        b = {8'h03, 8'h84, 8'hD1, 8'h00, 8'h03};
        e = {8'h03, 8'h06, 8'h80, 8'h00};
        pr(ra);
        run("bus a wrap");
        b = {8'h03, 8'h88, 8'hB9, 8'h00, 8'h03};
        e = {8'h03, 8'h06, 8'h01, 8'h00};
        pr(rb);
        run("bus b wrap");
        pt = {$urandom, $urandom};
        b = {8'h17, 8'h75, 8'h31, 8'h00, 8'h04, 8'h9C, 8'h41, 8'h00, 8'h06};
        b.push_back(8'h0C);
        wd(16'h9C41, 6);
        e = {8'h17, 8'h08};
        for (int k = 7; k >= 0; k--)
            e.push_back(pt[8*k +: 8]);
        run("pass-through");
        b = {8'h10, 8'hA0, 8'h29, 8'h00, 8'h04, 8'h08};
        wd(16'hA029, 4);
        e = {8'h10, 8'hA0, 8'h29, 8'h00, 8'h04};
        run("gear write");
        b = {8'h05, 8'h00, 8'h00, 8'h00, 8'h01};
        e = {8'h85, 8'h01};
        run("bad function");
        b = {8'h03, 8'h00, 8'h01, 8'h00, 8'h01};
        e = {8'h83, 8'h03};
        run("bad window");
        b = {8'h10, 8'hA0, 8'h29, 8'h00, 8'h04, 8'h02, 8'h00, 8'h00};
        e = {8'h90, 8'h03};
        run("bad byte count");
        close_out();
    end
endmodule
